/* File: rtl/uip_pkg.sv */
/*
  Package for the UART interrupt enable and priority block.
  Assumes a 40 MHz clock and a plain strobe register port.
*/
// Notes on behaviour
// - rx trigger reached raises receive interrupt
// - data ready set on fifo entry, cleared empty
// - all basic enables clear, enhanced off, means polled mode
// - line status bits carry documented meanings
// - mask bit 0 enables receive ready interrupt
// - mask bit 1 enables transmit ready, immediate
// - mask bit 2 enables line error interrupt
// - mask bit 3 enables modem status interrupt
// - mask bits 7..4 need enhanced enable
// - mask register resets to zero
// - rts/cts rising edge interrupts in auto mode
// - source read shows highest pending only
// - rx time-out raised by timer, cleared rhr read
// - tx ready cleared by source read or write
// - line read clears line, modem read clears modem
// - rx trigger clears below level only
// - xon/xoff/special match interrupt and clears
// - wake-up interrupt cleared by source read
// - source codes by priority one to seven
// - bit 0 low while pending, high at reset
// - bit 4 flags character match, enhanced only
// - bit 5 flags rts/cts rising, enhanced only
// - bits 7:6 show fifo enable
package uip_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [2:0] UIP_OFS_MASK = 3'h1;
  localparam logic [2:0] UIP_OFS_SOURCE = 3'h2;
  localparam logic [2:0] UIP_OFS_LINE = 3'h5;
  localparam logic [2:0] UIP_OFS_MODEM = 3'h6;
  localparam logic [2:0] UIP_OFS_HOLD = 3'h0;
  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] UIP_MASK_RST = 8'h00;
  localparam int UIP_EN_RX = 0;
  localparam int UIP_EN_TX = 1;
  localparam int UIP_EN_LINE = 2;
  localparam int UIP_EN_MODEM = 3;
  localparam int UIP_EN_XOFF = 5;
  localparam int UIP_EN_RTS = 6;
  localparam int UIP_EN_CTS = 7;
  // ----------------------------------------
  // source codes, bits 5..0
  // ----------------------------------------
  localparam logic [5:0] UIP_CODE_LINE = 6'h06;
  localparam logic [5:0] UIP_CODE_TOUT = 6'h0C;
  localparam logic [5:0] UIP_CODE_RX = 6'h04;
  localparam logic [5:0] UIP_CODE_TX = 6'h02;
  localparam logic [5:0] UIP_CODE_MODEM = 6'h00;
  localparam logic [5:0] UIP_CODE_CHAR = 6'h10;
  localparam logic [5:0] UIP_CODE_FLOW = 6'h20;
  localparam logic [5:0] UIP_CODE_NONE = 6'h01;
  // ----------------------------------------
  // register bus request
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uip_bus_t;
endpackage

/* File: rtl/uip_core.sv */
/*
  Interrupt mask and prioritised source logic of a 16-byte FIFO UART.
  Assumes fifo, receiver and flow engines on clk drive the status inputs;
  the cts pin level comes from outside and is synchronised here; the rts output level arrives on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module uip_core
  import uip_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire uip_bus_t bus, // register request
  output logic [7:0] rdata, // read data, cycle after read strobe
  input wire logic fifo_en, // fifo enable control
  input wire logic enh_en, // enhanced function enable
  input wire logic err_at_entry, // line errors flagged at fifo entry
  input wire logic auto_rts, // auto rts flow active
  input wire logic auto_cts, // auto cts flow active
  input wire logic wake_en, // wake-up interrupt enable
  input wire logic [4:0] rx_level, // receive fifo fill
  input wire logic [4:0] rx_trig, // receive trigger level
  input wire logic rx_push, // character entered receive fifo
  input wire logic rx_push_err, // that character has an error
  input wire logic [3:0] head_err, // break/frame/parity at head, bit 0 unused
  input wire logic overrun, // overrun pulse
  input wire logic fifo_err, // some fifo character has error
  input wire logic tx_ready, // tx below trigger or empty
  input wire logic tx_all_empty, // tx fifo and shift reg empty
  input wire logic tout, // time-out timer expired pulse
  input wire logic [3:0] modem_delta, // modem status bits 3..0
  input wire logic char_match, // xon/xoff match pulse
  input wire logic spec_match, // special char match pulse
  input wire logic woke, // left sleep mode pulse
  input wire logic cts_pin_n, // cts input pin
  input wire logic rts_out_n, // rts output level, same clock
  output logic irq, // host interrupt request
  output logic sleep_en // sleep enable to sleep logic
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] mask_r; // interrupt mask register
  logic [7:0] mask_eff; // mask after enhanced gating
  logic line_r, tout_r, tx_r, modem_r, char_r, flow_r, wake_r; // pending latches
  logic [2:0] cts_sync_r; // three stage pin synchroniser
  logic cts_lvl_r; // accepted cts level
  logic rts_d_r; // previous rts level
  logic tx_ready_d_r; // previous tx ready
  logic rx_pend; // receive trigger level pending
  logic [5:0] code; // current source code
  logic any_pend; // any enabled source pending
  logic rd_src, rd_line, rd_modem, rd_hold, wr_hold;
  logic cts_rise, rts_rise, line_ev;
  logic ovr_r; // overrun seen since the last line status read
  logic spec_r; // pending match came from the special character

  assign rd_src = bus.rd && bus.addr == UIP_OFS_SOURCE;
  assign rd_line = bus.rd && bus.addr == UIP_OFS_LINE;
  assign rd_modem = bus.rd && bus.addr == UIP_OFS_MODEM;
  assign rd_hold = bus.rd && bus.addr == UIP_OFS_HOLD;
  assign wr_hold = bus.wr && bus.addr == UIP_OFS_HOLD;

  // upper bits only count with enhanced functions on
  assign mask_eff = enh_en ? mask_r : {4'h0, mask_r[3:0]};
  assign sleep_en = mask_eff[4];

  // ----------------------------------------
  // mask register write
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= UIP_MASK_RST;
    end else if (bus.wr && bus.addr == UIP_OFS_MASK) begin
      mask_r <= bus.wdata;
    end
  end

  // ----------------------------------------
  // cts synchroniser and edge detect
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_sync_r <= 3'h0;
      cts_lvl_r <= 1'b0;
      rts_d_r <= 1'b0;
      tx_ready_d_r <= 1'b0;
    end else begin
      cts_sync_r <= {cts_sync_r[1:0], cts_pin_n};
      // level changes once stages two and three agree
      if (cts_sync_r[1] == cts_sync_r[2]) begin
        cts_lvl_r <= cts_sync_r[2];
      end
      rts_d_r <= rts_out_n;
      tx_ready_d_r <= tx_ready;
    end
  end
  assign cts_rise = cts_sync_r[1] && cts_sync_r[2] && !cts_lvl_r && auto_cts;
  assign rts_rise = rts_out_n && !rts_d_r && auto_rts;

  // error events: overrun immediately, others at head or entry
  assign line_ev = overrun || (err_at_entry ? (rx_push && rx_push_err) : |head_err[3:1]);

  // ----------------------------------------
  // pending latches; a new event beats a same-cycle clear
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_r <= 1'b0;
      tout_r <= 1'b0;
      modem_r <= 1'b0;
      flow_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      line_r <= line_ev || (line_r && !rd_line);
      ovr_r <= overrun || (ovr_r && !rd_line);
      tout_r <= tout || (tout_r && !rd_hold);
      modem_r <= (|modem_delta) || (modem_r && !rd_modem);
      flow_r <= cts_rise || rts_rise || (flow_r && !rd_modem);
    end
  end

  // tx ready: rising condition, or enabling while ready, arms it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_r <= 1'b0;
    end else if ((tx_ready && !tx_ready_d_r) ||
                 (bus.wr && bus.addr == UIP_OFS_MASK && bus.wdata[UIP_EN_TX] &&
                  !mask_r[UIP_EN_TX] && tx_ready)) begin
      tx_r <= 1'b1;
    end else if ((rd_src && code == UIP_CODE_TX) || wr_hold || !tx_ready) begin
      tx_r <= 1'b0;
    end
  end

  // character match; special clears on next arrival too
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      char_r <= 1'b0;
      wake_r <= 1'b0;
      spec_r <= 1'b0;
    end else begin
      if (char_match || spec_match) begin
        char_r <= 1'b1;
        // an xon/xoff match outranks a special one in the same cycle
        spec_r <= spec_match && !char_match;
      end else if (rd_src || (rx_push && spec_r)) begin
        char_r <= 1'b0;
        spec_r <= 1'b0;
      end
      wake_r <= (woke && wake_en) || (wake_r && !rd_src);
    end
  end

  // receive ready follows fifo level; level only falls through reads
  assign rx_pend = fifo_en ? (rx_level >= rx_trig) : (rx_level != 5'h00);

  // ----------------------------------------
  // priority encoder
  // ----------------------------------------
  always_comb begin
    any_pend = 1'b1;
    code = UIP_CODE_NONE;
    if (line_r && mask_eff[UIP_EN_LINE]) begin
      code = UIP_CODE_LINE;
    end else if (tout_r && mask_eff[UIP_EN_RX]) begin
      code = UIP_CODE_TOUT;
    end else if (rx_pend && mask_eff[UIP_EN_RX]) begin
      code = UIP_CODE_RX;
    end else if (tx_r && mask_eff[UIP_EN_TX]) begin
      code = UIP_CODE_TX;
    end else if (modem_r && mask_eff[UIP_EN_MODEM]) begin
      code = UIP_CODE_MODEM;
    end else if (char_r && mask_eff[UIP_EN_XOFF]) begin
      code = UIP_CODE_CHAR;
    end else if (flow_r && (mask_eff[UIP_EN_RTS] || mask_eff[UIP_EN_CTS])) begin
      code = UIP_CODE_FLOW;
    end else begin
      any_pend = 1'b0; // polled mode reaches here; wake-up reads as none
    end
  end
  assign irq = any_pend || wake_r;

  // ----------------------------------------
  // read data, one cycle after strobe
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        UIP_OFS_MASK: rdata <= mask_r;
        UIP_OFS_SOURCE: rdata <= {{2{fifo_en}}, code};
        UIP_OFS_LINE: rdata <= {fifo_err, tx_all_empty, tx_ready, head_err[3:1],
                                ovr_r, rx_level != 5'h00};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // host reads the source register
  sequence s_src_read;
    rd_src;
  endsequence
  // host reads the line status register
  sequence s_line_read;
    rd_line;
  endsequence
  // host reads the modem status register
  sequence s_modem_read;
    rd_modem;
  endsequence
  // transmit enable turned on while the holding side is already empty
  sequence s_tx_enable;
    bus.wr && bus.addr == UIP_OFS_MASK && bus.wdata[UIP_EN_TX] &&
      !mask_r[UIP_EN_TX] && tx_ready;
  endsequence
  // no fresh transmit-ready edge in this cycle, so a clear must win
  sequence s_tx_quiet;
    !(tx_ready && !tx_ready_d_r);
  endsequence
  // mask comes out of reset cleared, every source off
  AST_RESET_MASK: assert property (@(posedge clk) $rose(reset_n) |-> mask_r == 8'h00)
    else $error("mask not zero after reset");
  // nothing pending must read back as the none code
  AST_NONE_CODE: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == UIP_OFS_SOURCE && !any_pend |=> rdata[0])
    else $error("bit 0 low with nothing pending");
  // a lost request would leave the host polling forever
  AST_IRQ: assert property (@(posedge clk) disable iff (!reset_n) any_pend |-> irq)
    else $error("irq low while pending");
  // line read clears the line source unless a new error lands
  AST_LINE_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    s_line_read ##0 !line_ev |=> !line_r)
    else $error("line pending not cleared");
  // time-out pulse is one cycle wide and must not slip by
  AST_TOUT: assert property (@(posedge clk) disable iff (!reset_n) tout |=> tout_r)
    else $error("time-out lost");
  // top bits of the source read mirror the fifo enable
  AST_FIFOEN: assert property (@(posedge clk) disable iff (!reset_n)
    s_src_read |=> rdata[7:6] == {2{$past(fifo_en)}})
    else $error("fifo status bits wrong");
  // sleep is an enhanced feature
  AST_ENH: assert property (@(posedge clk) disable iff (!reset_n) !enh_en |-> !sleep_en)
    else $error("sleep without enhanced enable");
  // basic enables clear, enhanced functions off and no wake-up: the host only polls
  AST_POLL: assert property (@(posedge clk) disable iff (!reset_n)
    mask_r[3:0] == 4'h0 && !enh_en && !wake_r |-> !irq)
    else $error("interrupt in polled mode");
  // ----------------------------------------
  // transmit ready arming and clearing
  // ----------------------------------------
  // enabling transmit while ready must interrupt at once
  AST_TX_ARM: assert property (@(posedge clk) disable iff (!reset_n)
    s_tx_enable |=> tx_r)
    else $error("tx ready not armed by enable");
  // a holding register write services the transmit source
  AST_TX_HOLD_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    wr_hold ##0 s_tx_quiet |=> !tx_r)
    else $error("tx ready kept after holding write");
  // reading the source while it shows transmit services it
  AST_TX_SRC_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    s_src_read ##0 code == UIP_CODE_TX ##0 s_tx_quiet |=> !tx_r)
    else $error("tx ready kept after source read");
  // ----------------------------------------
  // modem, flow and match sources
  // ----------------------------------------
  // any modem delta bit raises the modem source
  AST_MODEM_SET: assert property (@(posedge clk) disable iff (!reset_n)
    |modem_delta |=> modem_r)
    else $error("modem change lost");
  // modem read clears the modem source when no delta arrives
  AST_MODEM_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    s_modem_read ##0 !(|modem_delta) |=> !modem_r)
    else $error("modem pending not cleared");
  // a qualified rising edge of either flow pin raises the flow source
  AST_FLOW_SET: assert property (@(posedge clk) disable iff (!reset_n)
    cts_rise || rts_rise |=> flow_r)
    else $error("flow edge lost");
  // modem read clears the flow source as well
  AST_FLOW_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    s_modem_read ##0 !cts_rise && !rts_rise |=> !flow_r)
    else $error("flow pending not cleared");
  // a settled cts level gives one edge only, not one per cycle
  AST_CTS_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
    cts_rise |=> !cts_rise)
    else $error("cts edge repeated");
  // xon, xoff or special match raises the match source
  AST_CHAR_SET: assert property (@(posedge clk) disable iff (!reset_n)
    char_match || spec_match |=> char_r)
    else $error("character match lost");
  // a source read clears the match source
  AST_CHAR_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    s_src_read ##0 !char_match && !spec_match |=> !char_r)
    else $error("match pending not cleared by source read");
  // a special match also clears when the next character lands
  AST_SPEC_NEXT: assert property (@(posedge clk) disable iff (!reset_n)
    rx_push && spec_r && !char_match && !spec_match |=> !char_r)
    else $error("special match not cleared by next character");
  // match and flow codes need the enhanced functions
  AST_ENH_CHAR: assert property (@(posedge clk) disable iff (!reset_n)
    !enh_en |-> code != UIP_CODE_CHAR && code != UIP_CODE_FLOW)
    else $error("enhanced code without enhanced enable");
  // sleep follows mask bit 4 once enhanced functions are on
  AST_SLEEP: assert property (@(posedge clk) disable iff (!reset_n)
    enh_en |-> sleep_en == mask_r[4])
    else $error("sleep enable does not follow mask");
  // ----------------------------------------
  // wake-up, priority and read data
  // ----------------------------------------
  // a source read clears the wake-up request
  AST_WAKE_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    s_src_read ##0 !(woke && wake_en) |=> !wake_r)
    else $error("wake-up not cleared");
  // wake-up alone requests service yet reads the none code
  AST_WAKE_CODE: assert property (@(posedge clk) disable iff (!reset_n)
    wake_r && !any_pend |-> code == UIP_CODE_NONE && irq)
    else $error("wake-up code or request wrong");
  // line status outranks every other source
  AST_PRIO_LINE: assert property (@(posedge clk) disable iff (!reset_n)
    line_r && mask_eff[UIP_EN_LINE] |-> code == UIP_CODE_LINE)
    else $error("line source not on top");
  // trigger reached with nothing above it shows receive ready
  AST_RX_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
    fifo_en && mask_eff[UIP_EN_RX] && rx_level >= rx_trig && !tout_r &&
      !(line_r && mask_eff[UIP_EN_LINE]) |-> code == UIP_CODE_RX)
    else $error("receive ready not shown at trigger");
  // below the trigger the receive code must be gone
  AST_RX_BELOW: assert property (@(posedge clk) disable iff (!reset_n)
    fifo_en && rx_level < rx_trig |-> code != UIP_CODE_RX)
    else $error("receive ready below trigger");
  // source read returns the code standing at the strobe
  AST_SRC_READ: assert property (@(posedge clk) disable iff (!reset_n)
    s_src_read |=> rdata[5:0] == $past(code))
    else $error("source read data wrong");
  // a pending source reads with bit 0 low
  AST_PEND_BIT: assert property (@(posedge clk) disable iff (!reset_n)
    s_src_read ##0 any_pend |=> !rdata[0])
    else $error("bit 0 high while pending");
  // overrun is flagged at once, not at the head of the fifo
  AST_OVR: assert property (@(posedge clk) disable iff (!reset_n)
    overrun |=> ovr_r)
    else $error("overrun flag lost");
  // every error event raises the line source
  AST_LINE_SET: assert property (@(posedge clk) disable iff (!reset_n)
    line_ev |=> line_r)
    else $error("line error lost");
  // data-ready bit follows fifo content, not the interrupt
  AST_DATA_READY: assert property (@(posedge clk) disable iff (!reset_n)
    s_line_read |=> rdata[0] == ($past(rx_level) != 5'h00))
    else $error("data ready bit wrong");
  // error type bits belong to the character at the head
  AST_LINE_BITS: assert property (@(posedge clk) disable iff (!reset_n)
    s_line_read |=> rdata[4:2] == $past(head_err[3:1]))
    else $error("error type bits wrong");
  // upper line bits show fifo error and transmit emptiness
  AST_LINE_TOP: assert property (@(posedge clk) disable iff (!reset_n)
    s_line_read |=> rdata[7:5] == {$past(fifo_err), $past(tx_all_empty), $past(tx_ready)})
    else $error("upper line status bits wrong");
  // time-out clears on a holding register read
  AST_TOUT_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    rd_hold && !tout |=> !tout_r)
    else $error("time-out not cleared");
  // read data only stand in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    !bus.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  // a mask write lands whole in one cycle
  AST_MASK_WR: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == UIP_OFS_MASK |=> mask_r == $past(bus.wdata))
    else $error("mask write lost");
endmodule
`default_nettype wire

/* File: testbench/uip_host.sv */
/*
  Host model: bus master on the register port of the interrupt block.
  Assumes the design's clock and read data one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module uip_host
  import uip_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var uip_bus_t bus
);
  // ------------------------------
  // bus idles at time zero
  // ------------------------------
  initial bus = '0;
  // one-cycle write strobe; strobes never overlap
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // data stand the one cycle after the strobe; take them at the edge that
  // closes that cycle, before the port drops them back to zero
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
/*
  Self-checking bench for the interrupt mask and source block.
  Assumes uip_host as bus master; status events are pulsed by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uip_pkg::*;
  // ------------------------------
  // stimulus and observed signals
  // ------------------------------
  logic clk, reset_n, fifo_en, enh_en, auto_rts, auto_cts, wake_en;
  logic cts_pin_n, rts_out_n, tx_ready, irq, sleep_en;
  logic tx_all_empty, fifo_err, err_entry; // line status levels and entry mode
  logic [4:0] rx_level;
  logic [3:0] head_err;
  logic [6:0] ev; // one bit per event pulse
  logic [7:0] rdata, d;
  uip_bus_t bus;
  int failures = 0;
  int n_compared = 0;
  uip_host host (.clk(clk), .rdata(rdata), .bus(bus));
  // trigger fixed at 4; in entry mode every pushed character carries an error
  uip_core uut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .fifo_en(fifo_en), .enh_en(enh_en), .err_at_entry(err_entry), .auto_rts(auto_rts),
    .auto_cts(auto_cts), .wake_en(wake_en), .rx_level(rx_level), .rx_trig(5'h04),
    .rx_push(ev[5]), .rx_push_err(err_entry), .head_err(head_err), .overrun(ev[0]),
    .fifo_err(fifo_err), .tx_ready(tx_ready), .tx_all_empty(tx_all_empty), .tout(ev[1]),
    .modem_delta({3'h0, ev[6]}), .char_match(ev[2]), .spec_match(ev[3]),
    .woke(ev[4]), .cts_pin_n(cts_pin_n), .rts_out_n(rts_out_n), .irq(irq),
    .sleep_en(sleep_en));
  // ------------------------------
  // clock, 25 ns period
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ------------------------------
  // helper tasks
  // ------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    repeat (4) @(posedge clk);
  endtask
  // pulse is one cycle, then let the three-flop pin sync settle too
  task automatic pulse(input logic [6:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= '0;
    tick();
  endtask
  // irq is combinational: look mid-cycle, then hand back on a rising edge
  task automatic chk_irq(input logic e);
    @(negedge clk);
    cmp8({7'h00, irq}, {7'h00, e});
    @(posedge clk);
  endtask
  task automatic chk_src(input logic [7:0] e);
    host.rd(UIP_OFS_SOURCE, d);
    cmp8(d, e);
  endtask
  task automatic wrap_up();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------
  // watchdog: the tests need well under 1000 cycles
  // ------------------------------
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    wrap_up();
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {reset_n, enh_en, auto_rts, auto_cts, wake_en, cts_pin_n, rts_out_n} = '0;
    {tx_ready, ev, rx_level, head_err} = '0;
    {tx_all_empty, fifo_err, err_entry} = '0;
    fifo_en = 1'b1;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    host.rd(UIP_OFS_MASK, d);
    cmp8(d, 8'h00);
    chk_src(8'hC1);
    @(posedge clk) tx_ready <= 1'b1;
    rx_level <= 5'h04;
    tick();
    chk_irq(1'b0);
    host.wr(UIP_OFS_MASK, 8'h02);
    chk_irq(1'b1);
    chk_src(8'hC2);
    chk_src(8'hC1);
    @(posedge clk) tx_ready <= 1'b0;
    tick();
    tx_ready <= 1'b1;
    tick();
    chk_irq(1'b1);
    host.wr(UIP_OFS_HOLD, 8'h55);
    chk_irq(1'b0);
    tx_ready <= 1'b0;
    host.wr(UIP_OFS_MASK, 8'h01);
    chk_src(8'hC4);
    @(posedge clk) rx_level <= 5'h03;
    tick();
    chk_src(8'hC1);
    host.wr(UIP_OFS_MASK, 8'h0F);
    rx_level <= 5'h04;
    head_err <= 4'h2;
    tick();
    chk_src(8'hC6);
    fifo_err <= 1'b1;
    host.rd(UIP_OFS_LINE, d);
    cmp8(d, 8'h85);
    head_err <= 4'h0;
    host.rd(UIP_OFS_LINE, d);
    cmp8(d, 8'h81);
    chk_src(8'hC4);
    pulse(7'h01);
    chk_src(8'hC6);
    tx_all_empty <= 1'b1;
    host.rd(UIP_OFS_LINE, d);
    cmp8(d, 8'hC3);
    err_entry <= 1'b1;
    pulse(7'h20);
    chk_src(8'hC6);
    host.rd(UIP_OFS_LINE, d);
    cmp8(d, 8'hC1);
    err_entry <= 1'b0;
    pulse(7'h02);
    chk_src(8'hCC);
    host.rd(UIP_OFS_HOLD, d);
    chk_src(8'hC4);
    rx_level <= 5'h00;
    pulse(7'h40);
    chk_src(8'hC0);
    host.rd(UIP_OFS_MODEM, d);
    chk_src(8'hC1);
    host.wr(UIP_OFS_MASK, 8'hF0);
    pulse(7'h04);
    chk_irq(1'b0);
    cmp8({7'h00, sleep_en}, 8'h00);
    @(posedge clk) enh_en <= 1'b1;
    host.rd(UIP_OFS_SOURCE, d);
    cmp8({7'h00, sleep_en}, 8'h01);
    pulse(7'h04);
    chk_src(8'hD0);
    chk_src(8'hC1);
    pulse(7'h08);
    chk_irq(1'b1);
    pulse(7'h20);
    chk_irq(1'b0);
    auto_cts <= 1'b1;
    cts_pin_n <= 1'b1;
    tick();
    chk_src(8'hE0);
    host.rd(UIP_OFS_MODEM, d);
    chk_irq(1'b0);
    auto_rts <= 1'b1;
    rts_out_n <= 1'b1;
    tick();
    chk_irq(1'b1);
    host.rd(UIP_OFS_MODEM, d);
    wake_en <= 1'b1;
    pulse(7'h10);
    chk_irq(1'b1);
    chk_src(8'hC1);
    chk_irq(1'b0);
    fifo_en <= 1'b0;
    tick();
    chk_src(8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire
